/* brake_defines.svh */
// register offsets, reset values and timing constants of the brake interlock sequencer
`ifndef BRAKE_DEFINES_SVH
`define BRAKE_DEFINES_SVH

// ==========================================================
// register byte offsets
`define OFS_OUT_SEL 8'h00
`define OFS_SERVO_WAIT 8'h04
`define OFS_BASIC_WAIT 8'h08
`define OFS_BRAKE_SPEED 8'h0C
`define OFS_BRAKE_TIME 8'h10
`define OFS_BASIC_FUNC 8'h14
`define OFS_STATUS 8'h18
`define OFS_SINGLETURN 8'h1C
`define OFS_MULTITURN 8'h20
`define OFS_IRQ_STAT 8'h24
`define OFS_IRQ_MASK 8'h28

// ==========================================================
// reset values and setting limits
`define RST_OUT_SEL 12'h000
`define RST_SERVO_WAIT 16'h0000
`define RST_BASIC_WAIT 9'h000
`define RST_BRAKE_SPEED 7'h64
`define RST_BRAKE_TIME 7'h32
`define RST_BASIC_FUNC 16'h0000
`define SERVO_WAIT_MAX 16'sh07D0
`define SERVO_WAIT_MIN (-16'sh07D0)
`define BASIC_WAIT_MAX 9'h1F4
`define BRAKE_SPEED_MIN 7'h0A
`define BRAKE_SPEED_MAX 7'h64
`define BRAKE_TIME_MIN 7'h0A
`define BRAKE_TIME_MAX 7'h64

// ==========================================================
// field positions and codes
`define FUNC_BRAKE 4'h4
`define FUNC_LAST 4'h9
`define PL_DIGIT_HI 15
`define PL_DIGIT_LO 12
`define PL_ALARM 4'h1
`define STAT_PL_ALARM 3
`define SINGLE_MAX 17'h1FFFF

// ==========================================================
// timing
`define CLK_FREQ_HZ 40000000
`define MS_PER_S 1000
`define WAIT_UNIT_MS 10
`define MS_CYCLES (`CLK_FREQ_HZ / `MS_PER_S)

`endif

/* brake_pkg.sv */
// types shared by the brake interlock sequencer
package brake_pkg;
	typedef enum logic [2:0] {ST_OFF, ST_ON_WAIT, ST_ON, ST_OFF_WAIT, ST_RUN_STOP} seq_state_e;
	typedef logic [3:0] func_code_t;
	typedef logic [9:0] func_vec_t;
endpackage

/* ms_tick.sv */
// millisecond tick generator
`timescale 1ns/1ps
module ms_tick #(
	parameter int MS_CYCLES = 40000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	output logic tick_o
);

	logic [31:0] cnt_reg;
	logic [31:0] cnt_next;
	wire wrap = (cnt_reg == 32'(MS_CYCLES - 1));

	assign cnt_next = wrap ? 32'h0000_0000 : cnt_reg + 32'h0000_0001;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cnt_reg <= 32'h0000_0000;
			tick_o <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_o <= wrap;
		end
	end

endmodule

/* abs_position.sv */
// absolute position counter: 17-bit single-turn and signed 16-bit multiturn
`timescale 1ns/1ps
`include "brake_defines.svh"
module abs_position (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic step_fwd_i,
	input wire logic step_rev_i,
	output logic [16:0] single_o,
	output logic [15:0] multi_o,
	output logic wrap_o
);

	wire fwd = step_fwd_i & ~step_rev_i;
	wire rev = step_rev_i & ~step_fwd_i;
	wire carry = fwd & (single_o == `SINGLE_MAX);
	wire borrow = rev & (single_o == 17'h00000);
	// two's complement rollover gives +32767 -> -32768 and back
	wire [15:0] multi_next = carry ? multi_o + 16'h0001 : borrow ? multi_o - 16'h0001 : multi_o;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			single_o <= 17'h00000;
			multi_o <= 16'h0000;
			wrap_o <= 1'b0;
		end
		else
		begin
			single_o <= fwd ? single_o + 17'h00001 : rev ? single_o - 17'h00001 : single_o;
			multi_o <= multi_next;
			wrap_o <= (carry & (multi_o == 16'h7FFF)) | (borrow & (multi_o == 16'h8000));
		end
	end

endmodule

/* brake_interlock_sequencer.sv */
// brake interlock sequencer with wishbone register file and output terminal routing
//
// Operation
// - the brake interlock output is low to release the holding brake and high to apply it.
// - out of reset the brake interlock is routed to no terminal and stays inactive.
// - function code 4 in any of the three allocation digits routes the brake to that pair.
// - each allocation digit picks one of the ten output functions by its code 0 to 9.
// - with default waits the brake is applied in the same cycle the servo turns off.
// - signed servo wait plus basic interval in 10 ms units shift servo against brake.
// - an alarm turns the servo off at once, ignoring the servo-off wait.
// - the running-stop conditions apply to stops from servo off or from an alarm.
// - while running down the brake applies once speed falls below the brake wait speed.
// - while running down the brake also applies once the brake wait time has run out.
// - the top basic function digit picks continue (0) or alarm (1) on supply loss.
// - position is 17-bit single-turn plus signed 16-bit multiturn, +32767 wraps to -32768.
// - counting down below -32768 wraps the multiturn count to +32767.
//
// Local design decisions: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`include "brake_defines.svh"
module brake_interlock_sequencer
	import brake_pkg::*;
#(
	parameter int MS_CYCLES = `MS_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic servo_on_i,
	input wire logic alarm_i,
	input wire logic power_loss_i,
	input wire logic [15:0] speed_rpm_i,
	input wire logic enc_fwd_i,
	input wire logic enc_rev_i,
	input wire logic [9:0] func_src_i,
	output logic servo_enable_o,
	output logic brake_release_n_o,
	output logic [2:0] out_term_n_o,
	output logic power_loss_alarm_o,
	output logic irq_o
);

	// ==========================================================
	// functions

	function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] m;
		m = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old & ~m) | (nw & m);
	endfunction

	function automatic logic [6:0] clamp7(input logic [31:0] v, input logic [6:0] lo,
		input logic [6:0] hi);
		if (v < {25'h0, lo})
			return lo;
		else if (v > {25'h0, hi})
			return hi;
		else
			return v[6:0];
	endfunction

	function automatic logic select_function(input func_code_t code, input func_vec_t src);
		if (code > `FUNC_LAST)
			return 1'b0;
		else
			return src[code];
	endfunction

	// ==========================================================
	// registers

	logic [11:0] out_sel_reg;
	logic [15:0] servo_wait_reg;
	logic [8:0] basic_wait_reg;
	logic [6:0] brake_speed_reg;
	logic [6:0] brake_time_reg;
	logic [15:0] basic_func_reg;
	logic [3:0] irq_stat_reg;
	logic [3:0] irq_mask_reg;
	logic pl_alarm_reg;
	logic [16:0] ms_cnt_reg;
	seq_state_e state_reg;
	seq_state_e state_next;
	logic servo_en_next;
	logic brake_rel_next;
	logic brake_rel_reg;

	// ==========================================================
	// bus decode

	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire wr_out_sel = bus_wr & (wb_adr_i == `OFS_OUT_SEL);
	wire wr_servo_wait = bus_wr & (wb_adr_i == `OFS_SERVO_WAIT);
	wire wr_basic_wait = bus_wr & (wb_adr_i == `OFS_BASIC_WAIT);
	wire wr_brake_speed = bus_wr & (wb_adr_i == `OFS_BRAKE_SPEED);
	wire wr_brake_time = bus_wr & (wb_adr_i == `OFS_BRAKE_TIME);
	wire wr_basic_func = bus_wr & (wb_adr_i == `OFS_BASIC_FUNC);
	wire wr_status = bus_wr & (wb_adr_i == `OFS_STATUS);
	wire wr_irq_stat = bus_wr & (wb_adr_i == `OFS_IRQ_STAT);
	wire wr_irq_mask = bus_wr & (wb_adr_i == `OFS_IRQ_MASK);

	wire [31:0] m_out_sel = lane_merge({20'h0, out_sel_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_servo_wait = lane_merge({16'h0, servo_wait_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_basic_wait = lane_merge({23'h0, basic_wait_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_brake_speed = lane_merge({25'h0, brake_speed_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_brake_time = lane_merge({25'h0, brake_time_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_basic_func = lane_merge({16'h0, basic_func_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] m_irq_mask = lane_merge({28'h0, irq_mask_reg}, wb_dat_i, wb_sel_i);
	wire [31:0] w1c_data = lane_merge(32'h0000_0000, wb_dat_i, wb_sel_i);

	// settings are clamped to their legal range on write
	wire signed [15:0] sw_in = m_servo_wait[15:0];
	wire [15:0] servo_wait_wr = (sw_in > `SERVO_WAIT_MAX) ? `SERVO_WAIT_MAX :
		(sw_in < `SERVO_WAIT_MIN) ? `SERVO_WAIT_MIN : sw_in;
	wire [8:0] basic_wait_wr = (m_basic_wait > {23'h0, `BASIC_WAIT_MAX}) ?
		`BASIC_WAIT_MAX : m_basic_wait[8:0];
	wire [6:0] brake_speed_wr = clamp7(m_brake_speed, `BRAKE_SPEED_MIN, `BRAKE_SPEED_MAX);
	wire [6:0] brake_time_wr = clamp7(m_brake_time, `BRAKE_TIME_MIN, `BRAKE_TIME_MAX);

	// ==========================================================
	// helpers

	logic tick;
	logic [16:0] single_turn;
	logic [15:0] multi_turn;
	logic wrap_evt;

	ms_tick #(
		.MS_CYCLES(MS_CYCLES)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	abs_position u_pos (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.step_fwd_i(enc_fwd_i),
		.step_rev_i(enc_rev_i),
		.single_o(single_turn),
		.multi_o(multi_turn),
		.wrap_o(wrap_evt)
	);

	// ==========================================================
	// power loss response

	wire pl_alarm_mode = basic_func_reg[`PL_DIGIT_HI:`PL_DIGIT_LO] == `PL_ALARM;
	wire pl_set = power_loss_i & pl_alarm_mode;
	wire pl_clr = wr_status & w1c_data[`STAT_PL_ALARM];
	wire pl_alarm_next = pl_set | (pl_alarm_reg & ~pl_clr);
	wire pl_evt = pl_set & ~pl_alarm_reg;

	// ==========================================================
	// sequencing conditions

	wire alarm_any = alarm_i | pl_alarm_reg;
	wire run_req = servo_on_i & ~alarm_any;
	wire moving = speed_rpm_i >= {9'h000, brake_speed_reg};
	wire signed [17:0] sw_ms = {{2{servo_wait_reg[15]}}, servo_wait_reg};
	wire signed [17:0] bw_ms = 18'(basic_wait_reg * `WAIT_UNIT_MS);
	wire signed [17:0] wait_total = sw_ms + bw_ms;
	wire wait_neg = wait_total[17];
	wire [17:0] wait_mag = wait_neg ? 18'(-wait_total) : wait_total;
	wire wait_done = {1'b0, ms_cnt_reg} >= wait_mag;
	wire wait_zero = wait_mag == 18'h00000;
	wire [16:0] brake_time_ms = 17'(brake_time_reg * `WAIT_UNIT_MS);
	wire brake_time_done = ms_cnt_reg >= brake_time_ms;
	wire [16:0] ms_cnt_next = (state_next != state_reg) ? 17'h00000 :
		(tick & ~&ms_cnt_reg) ? ms_cnt_reg + 17'h00001 : ms_cnt_reg;

	// ==========================================================
	// servo and brake sequencer

	always_comb
	begin
		state_next = state_reg;
		servo_en_next = servo_enable_o;
		brake_rel_next = brake_rel_reg;
		case (state_reg)
			ST_OFF:
			begin
				servo_en_next = 1'b0;
				brake_rel_next = 1'b0;
				if (run_req)
				begin
					state_next = ST_ON_WAIT;
					if (wait_neg)
						brake_rel_next = 1'b1;
					else
						servo_en_next = 1'b1;
				end
			end
			ST_ON_WAIT, ST_ON:
			begin
				if (!run_req && (alarm_any || moving))
				begin
					servo_en_next = 1'b0;
					if (moving)
						state_next = ST_RUN_STOP;
					else
					begin
						brake_rel_next = 1'b0;
						state_next = ST_OFF;
					end
				end
				else if (!run_req)
				begin
					if (wait_neg)
						servo_en_next = 1'b0;
					else
						brake_rel_next = 1'b0;
					if (wait_zero)
					begin
						servo_en_next = 1'b0;
						brake_rel_next = 1'b0;
						state_next = ST_OFF;
					end
					else
						state_next = ST_OFF_WAIT;
				end
				else if (state_reg == ST_ON_WAIT && wait_done)
				begin
					servo_en_next = 1'b1;
					brake_rel_next = 1'b1;
					state_next = ST_ON;
				end
			end
			ST_OFF_WAIT:
			begin
				if (wait_done || alarm_any)
				begin
					servo_en_next = 1'b0;
					brake_rel_next = 1'b0;
					state_next = ST_OFF;
				end
			end
			ST_RUN_STOP:
			begin
				servo_en_next = 1'b0;
				if (!moving || brake_time_done)
				begin
					brake_rel_next = 1'b0;
					state_next = ST_OFF;
				end
			end
			default:
			begin
				state_next = ST_OFF;
				servo_en_next = 1'b0;
				brake_rel_next = 1'b0;
			end
		endcase
	end

	// ==========================================================
	// output routing

	genvar g;
	logic [2:0] brake_routed;
	logic [2:0] term_next;
	func_vec_t src_vec;
	assign src_vec = {func_src_i[9:5], brake_rel_next, func_src_i[3:0]};

	generate
		for (g = 0; g < 3; g++)
		begin : g_term
			wire func_code_t code = out_sel_reg[4*g+3:4*g];
			assign brake_routed[g] = code == `FUNC_BRAKE;
			// terminal is low while its function is on
			assign term_next[g] = ~select_function(code, src_vec);
		end
	endgenerate

	wire brake_assigned = |brake_routed;
	wire brake_n_next = ~(brake_rel_next & brake_assigned);

	// ==========================================================
	// interrupts

	wire brake_apply_evt = brake_n_next & ~brake_release_n_o;
	wire brake_rel_evt = ~brake_n_next & brake_release_n_o;
	wire [3:0] irq_evt = {wrap_evt, pl_evt, brake_rel_evt, brake_apply_evt};
	wire [3:0] irq_clr = wr_irq_stat ? w1c_data[3:0] : 4'h0;
	wire [3:0] irq_stat_next = irq_evt | (irq_stat_reg & ~irq_clr);
	wire [3:0] irq_mask_next = wr_irq_mask ? m_irq_mask[3:0] : irq_mask_reg;

	// ==========================================================
	// read mux

	wire [31:0] status_word = {24'h0, 1'b0, state_reg, pl_alarm_reg, brake_assigned,
		brake_rel_reg, servo_enable_o};
	wire [31:0] rd_data =
		(wb_adr_i == `OFS_OUT_SEL) ? {20'h0, out_sel_reg} :
		(wb_adr_i == `OFS_SERVO_WAIT) ? {{16{servo_wait_reg[15]}}, servo_wait_reg} :
		(wb_adr_i == `OFS_BASIC_WAIT) ? {23'h0, basic_wait_reg} :
		(wb_adr_i == `OFS_BRAKE_SPEED) ? {25'h0, brake_speed_reg} :
		(wb_adr_i == `OFS_BRAKE_TIME) ? {25'h0, brake_time_reg} :
		(wb_adr_i == `OFS_BASIC_FUNC) ? {16'h0, basic_func_reg} :
		(wb_adr_i == `OFS_STATUS) ? status_word :
		(wb_adr_i == `OFS_SINGLETURN) ? {15'h0, single_turn} :
		(wb_adr_i == `OFS_MULTITURN) ? {{16{multi_turn[15]}}, multi_turn} :
		(wb_adr_i == `OFS_IRQ_STAT) ? {28'h0, irq_stat_reg} :
		(wb_adr_i == `OFS_IRQ_MASK) ? {28'h0, irq_mask_reg} : 32'h0000_0000;

	// ==========================================================
	// settings registers

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			out_sel_reg <= `RST_OUT_SEL;
			servo_wait_reg <= `RST_SERVO_WAIT;
			basic_wait_reg <= `RST_BASIC_WAIT;
			brake_speed_reg <= `RST_BRAKE_SPEED;
			brake_time_reg <= `RST_BRAKE_TIME;
			basic_func_reg <= `RST_BASIC_FUNC;
		end
		else
		begin
			if (wr_out_sel)
				out_sel_reg <= m_out_sel[11:0];
			if (wr_servo_wait)
				servo_wait_reg <= servo_wait_wr;
			if (wr_basic_wait)
				basic_wait_reg <= basic_wait_wr;
			if (wr_brake_speed)
				brake_speed_reg <= brake_speed_wr;
			if (wr_brake_time)
				brake_time_reg <= brake_time_wr;
			if (wr_basic_func)
				basic_func_reg <= m_basic_func[15:0];
		end
	end

	// ==========================================================
	// bus answer

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req & ~wb_we_i) ? rd_data : 32'h0000_0000;
		end
	end

	// ==========================================================
	// sequencer state and outputs

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state_reg <= ST_OFF;
			ms_cnt_reg <= 17'h00000;
			servo_enable_o <= 1'b0;
			brake_rel_reg <= 1'b0;
			brake_release_n_o <= 1'b1;
			out_term_n_o <= 3'b111;
		end
		else
		begin
			state_reg <= state_next;
			ms_cnt_reg <= ms_cnt_next;
			servo_enable_o <= servo_en_next;
			brake_rel_reg <= brake_rel_next;
			brake_release_n_o <= brake_n_next;
			out_term_n_o <= term_next;
		end
	end

	// ==========================================================
	// alarm and interrupt state

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pl_alarm_reg <= 1'b0;
			power_loss_alarm_o <= 1'b0;
			irq_stat_reg <= 4'h0;
			irq_mask_reg <= 4'h0;
			irq_o <= 1'b0;
		end
		else
		begin
			pl_alarm_reg <= pl_alarm_next;
			power_loss_alarm_o <= pl_alarm_next;
			irq_stat_reg <= irq_stat_next;
			irq_mask_reg <= irq_mask_next;
			irq_o <= |(irq_stat_next & irq_mask_next);
		end
	end

endmodule

/* brake_checker.sv */
// port assertions of the brake interlock sequencer
`timescale 1ns/1ps
module brake_checker #(
	parameter int MS_CYCLES = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_ack_o,
	input wire logic servo_on_i,
	input wire logic alarm_i,
	input wire logic power_loss_i,
	input wire logic [15:0] speed_rpm_i,
	input wire logic servo_enable_o,
	input wire logic brake_release_n_o,
	input wire logic [2:0] out_term_n_o,
	input wire logic power_loss_alarm_o
);
	// ======
	// released brake on a de-energised motor has a bounded life
	localparam int LIMIT = 2001 * MS_CYCLES + 4;
	logic [31:0] off_cnt_reg;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || servo_enable_o || brake_release_n_o)
			off_cnt_reg <= 32'h0;
		else
			off_cnt_reg <= off_cnt_reg + 32'h1;
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	reset_brake_a: assert property (disable iff (1'b0) rst_i |=> brake_release_n_o)
		else $error("brake not applied in reset");
	release_cmd_a: assert property ($fell(brake_release_n_o) |-> $past(servo_on_i)
		&& !$past(alarm_i) && !$past(power_loss_alarm_o))
		else $error("brake released without servo on");
	alarm_off_a: assert property (alarm_i |=> !servo_enable_o)
		else $error("servo still on after alarm");
	stopped_alarm_a: assert property (alarm_i && speed_rpm_i < 16'h000A |=> brake_release_n_o)
		else $error("brake not applied on stopped alarm");
	off_time_a: assert property (off_cnt_reg <= LIMIT)
		else $error("brake released too long after servo off");
	release_route_a: assert property (!brake_release_n_o && $past(!brake_release_n_o)
		|-> out_term_n_o != 3'h7)
		else $error("released brake routed to no terminal");
	pl_cause_a: assert property ($rose(power_loss_alarm_o) |-> $past(power_loss_i))
		else $error("supply alarm without supply loss");
	pl_servo_a: assert property (power_loss_alarm_o |=> !servo_enable_o)
		else $error("servo on during supply alarm");
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
endmodule
bind brake_interlock_sequencer brake_checker #(.MS_CYCLES(MS_CYCLES)) brake_checker_inst (
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_ack_o(wb_ack_o),
	.servo_on_i(servo_on_i),
	.alarm_i(alarm_i),
	.power_loss_i(power_loss_i),
	.speed_rpm_i(speed_rpm_i),
	.servo_enable_o(servo_enable_o),
	.brake_release_n_o(brake_release_n_o),
	.out_term_n_o(out_term_n_o),
	.power_loss_alarm_o(power_loss_alarm_o)
);

/* brake_relay_model.sv */
// brake relay and brake supply behind the interlock terminal
`timescale 1ns/1ps
module brake_relay_model #(
	parameter int HOLD_RPM = 100
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic coil_n_i,
	input wire logic [15:0] speed_rpm_i,
	output logic brake_held_o,
	output logic [7:0] misuse_o
);
	// ======
	// relay pulls in on a low terminal and lets the brake go
	logic coil_n_reg;
	assign brake_held_o = coil_n_i;
	always_ff @(posedge clk_i)
	begin
		coil_n_reg <= rst_i | coil_n_i;
		if (rst_i)
			misuse_o <= 8'h00;
		else if (coil_n_i && !coil_n_reg && speed_rpm_i >= HOLD_RPM)
			misuse_o <= misuse_o + 8'h01;
	end
endmodule

/* test_brake_interlock_sequencer.sv */
// self-checking testbench of the brake interlock sequencer
`timescale 1ns/1ps
`include "brake_defines.svh"
module test_brake_interlock_sequencer;
	localparam int MS = 4;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0, stb = 1'b0, we = 1'b0, son = 1'b0, alm = 1'b0, pl = 1'b0;
	logic fwd = 1'b0, rev = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] dw = 32'h0, dr, rd;
	logic [15:0] spd = 16'h0000;
	logic [9:0] fsrc = 10'h000;
	logic ack, sen, brk_n, pla, irq, held;
	logic [2:0] term_n;
	logic [7:0] mis;
	int errors = 0, n_checks = 0, n;
	initial forever #12.5 clk_i = ~clk_i;
	brake_interlock_sequencer #(.MS_CYCLES(MS)) brake_interlock_sequencer_inst (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(dw), .wb_dat_o(dr), .wb_ack_o(ack), .servo_on_i(son),
		.alarm_i(alm), .power_loss_i(pl), .speed_rpm_i(spd), .enc_fwd_i(fwd), .enc_rev_i(rev),
		.func_src_i(fsrc), .servo_enable_o(sen), .brake_release_n_o(brk_n),
		.out_term_n_o(term_n), .power_loss_alarm_o(pla), .irq_o(irq));
	brake_relay_model brake_relay_model_inst (.clk_i(clk_i), .rst_i(rst_i),
		.coil_n_i(term_n[0]), .speed_rpm_i(spd), .brake_held_o(held), .misuse_o(mis));
	// ======
	// shared tasks
	task automatic complete_run;
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			errors++;
			$display("[ERR] %s expected %h seen %h", s, exp, seen);
		end
	endtask
	task automatic step(input int k);
		repeat (k) @(posedge clk_i);
		#2;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dw <= d;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack !== 1'b1 && k < 50);
		rd = dr;
		cyc <= 1'b0;
		stb <= 1'b0;
		if (ack !== 1'b1)
		begin
			errors++;
			complete_run();
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
		wb(1'b0, a, 32'h0);
		check(s, rd, e);
	endtask
	task automatic waitfor(input int sig, input logic lvl, input int lim);
		n = 0;
		while (((sig == 0) ? brk_n : sen) !== lvl && n < lim)
		begin
			step(1);
			n++;
		end
		if (n >= lim)
		begin
			errors++;
			complete_run();
		end
	endtask
	task automatic pulse_pl;
		@(posedge clk_i) pl <= 1'b1;
		@(posedge clk_i) pl <= 1'b0;
		step(2);
	endtask
	// ======
	// scenarios
	task automatic t_reset;
		check("brake pin", brk_n, 1'h1);
		check("terminals", term_n, 3'h7);
		rchk(`OFS_OUT_SEL, 32'h0, "out sel");
		rchk(`OFS_BRAKE_SPEED, 32'h64, "wait speed");
		rchk(`OFS_BRAKE_TIME, 32'h32, "wait time");
		rchk(`OFS_SERVO_WAIT, 32'h0, "servo wait");
		rchk(8'h3C, 32'h0, "unmapped");
		@(posedge clk_i) son <= 1'b1;
		step(3);
		check("unassigned", brk_n, 1'h1);
		@(posedge clk_i) son <= 1'b0;
		$display("reset test done");
	endtask
	task automatic t_route;
		for (int k = 0; k < 11; k++)
		begin
			if (k == 4)
				continue;
			wb(1'b1, `OFS_OUT_SEL, k);
			@(posedge clk_i) fsrc <= 10'h3FF ^ (10'h1 << k);
			step(2);
			check("func off", term_n[0], 1'h1);
			@(posedge clk_i) fsrc <= 10'h1 << k;
			step(2);
			check("func on", term_n[0], (k > 9) ? 1'h1 : 1'h0);
		end
		@(posedge clk_i) fsrc <= 10'h000;
		for (int d = 0; d < 3; d++)
		begin
			wb(1'b1, `OFS_OUT_SEL, 32'h4 << (4 * d));
			@(posedge clk_i) son <= 1'b1;
			step(1);
			check("energise", {sen, brk_n}, 2'h3);
			step(1);
			check("released", brk_n, 1'h0);
			step(1);
			check("route", term_n, 3'h7 ^ (3'h1 << d));
			@(posedge clk_i) son <= 1'b0;
			step(1);
			check("off same cycle", {sen, brk_n}, 2'h1);
		end
		wb(1'b1, `OFS_OUT_SEL, 32'h4);
		$display("route test done");
	endtask
	task automatic t_wait;
		wb(1'b1, `OFS_SERVO_WAIT, 32'hBB8);
		rchk(`OFS_SERVO_WAIT, 32'h7D0, "wait clamp");
		wb(1'b1, `OFS_SERVO_WAIT, 32'h5);
		@(posedge clk_i) son <= 1'b1;
		step(1);
		waitfor(0, 1'b0, 40);
		check("on delay", n >= 4 * MS - 2 && n <= 5 * MS + 2, 1'h1);
		@(posedge clk_i) son <= 1'b0;
		step(1);
		check("brake first", {sen, brk_n}, 2'h3);
		waitfor(1, 1'b0, 40);
		check("off delay", n >= 4 * MS - 2 && n <= 5 * MS + 2, 1'h1);
		@(posedge clk_i) son <= 1'b1;
		waitfor(0, 1'b0, 40);
		@(posedge clk_i) alm <= 1'b1;
		step(1);
		check("alarm stop", {sen, brk_n}, 2'h1);
		@(posedge clk_i) son <= 1'b0;
		alm <= 1'b0;
		wb(1'b1, `OFS_SERVO_WAIT, 32'h0);
		$display("wait test done");
	endtask
	task automatic t_run;
		@(posedge clk_i) son <= 1'b1;
		waitfor(0, 1'b0, 10);
		@(posedge clk_i) spd <= 16'h01F4;
		@(posedge clk_i) son <= 1'b0;
		step(20);
		check("run stop", {sen, brk_n}, 2'h0);
		check("relay free", held, 1'h0);
		@(posedge clk_i) spd <= 16'h0064;
		step(3);
		check("at wait speed", brk_n, 1'h0);
		@(posedge clk_i) spd <= 16'h0063;
		step(2);
		check("below speed", brk_n, 1'h1);
		check("relay held", held, 1'h1);
		wb(1'b1, `OFS_BRAKE_TIME, 32'h1);
		rchk(`OFS_BRAKE_TIME, 32'hA, "time clamp");
		@(posedge clk_i) son <= 1'b1;
		waitfor(0, 1'b0, 10);
		@(posedge clk_i) spd <= 16'h01F4;
		@(posedge clk_i) alm <= 1'b1;
		step(1);
		check("alarm run", {sen, brk_n}, 2'h0);
		waitfor(0, 1'b1, 500);
		check("time brake", n >= 99 * MS - 3 && n <= 100 * MS + 2, 1'h1);
		step(2);
		check("relay misuse", mis, 8'h1);
		@(posedge clk_i) alm <= 1'b0;
		son <= 1'b0;
		spd <= 16'h0000;
		$display("run test done");
	endtask
	task automatic t_power;
		wb(1'b1, `OFS_IRQ_MASK, 32'h4);
		pulse_pl();
		check("continue", {pla, irq}, 2'h0);
		wb(1'b1, `OFS_BASIC_FUNC, 32'h1000);
		pulse_pl();
		check("supply alarm", {pla, irq}, 2'h3);
		@(posedge clk_i) son <= 1'b1;
		step(4);
		check("alarm holds", {sen, brk_n}, 2'h1);
		@(posedge clk_i) son <= 1'b0;
		wb(1'b1, `OFS_STATUS, 32'h8);
		wb(1'b1, `OFS_IRQ_STAT, 32'h4);
		step(2);
		check("cleared", {pla, irq}, 2'h0);
		$display("power test done");
	endtask
	task automatic t_pos;
		@(posedge clk_i) rev <= 1'b1;
		@(posedge clk_i) rev <= 1'b0;
		rchk(`OFS_SINGLETURN, 32'h1FFFF, "single rev");
		rchk(`OFS_MULTITURN, 32'hFFFFFFFF, "multi rev");
		@(posedge clk_i) fwd <= 1'b1;
		@(posedge clk_i) fwd <= 1'b0;
		rchk(`OFS_SINGLETURN, 32'h0, "single fwd");
		rchk(`OFS_MULTITURN, 32'h0, "multi fwd");
		$display("position test done");
	endtask
	initial
	begin
		repeat (20) @(posedge clk_i);
		rst_i <= 1'b0;
		step(1);
		t_reset();
		t_route();
		t_wait();
		t_run();
		t_power();
		t_pos();
		complete_run();
	end
endmodule
